// ---- src/acr_ctrl.sv ----
// Converter control register 0 with APB slave, status flags and interrupt output.
`timescale 1ns/1ns
// Function
// - Bit 7 of the control register is unimplemented, reads zero and ignores writes.
// - Selector codes 0 to 7 in bits 6..2 route analogue inputs 0 to 7 in order.
// - Selector codes 8 and 9 route analogue inputs 8 and 9 of the larger package.
// - Selector codes 12 through 28 are reserved and connect no channel.
// - Codes 29, 30 and 31 route the temperature indicator, the DAC output and the reference.
// - Writing one to the start/busy bit begins a conversion and it reads one while busy.
// - Hardware clears the start/busy bit one clock after completion sets the done flag.
// - The start/busy bit reads zero when neither a conversion nor its finishing clock is under way.
// - Bit 0 enables the converter, and when zero the converter draws no current.
// - All implemented bits are read/write and reset to zero on any reset.
// - Completion sets the done flag and loads the result into the high and low registers.
// - Clearing the start/busy bit early stops the conversion and stores a partial result.
// - A special event trigger sets the start/busy bit in hardware.
module acr_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic special_trigger,
    input wire logic engine_done,
    input wire logic [acr_pkg::ACR_RES_W-1:0] engine_result,
    output logic engine_start,
    output logic engine_abort,
    output logic converter_enable,
    output logic [acr_pkg::ACR_NSRC-1:0] route_onehot,
    output logic route_none,
    output logic [7:0] result_high,
    output logic [7:0] result_low,
    output logic irq
);
    import acr_pkg::*;

    logic [7:0] ctrl_reg, ctrl_next;
    logic [1:0] stat_reg, stat_next;
    logic [1:0] mask_reg, mask_next;
    logic [9:0] res_reg, res_next;
    acr_state_e state_reg, state_next;
    logic start_reg, start_next;
    logic abort_reg, abort_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pready_reg, pready_next;
    logic pslverr_reg, pslverr_next;
    logic irq_reg, irq_next;
    logic [12:0] route_reg;
    logic none_reg;
    logic [12:0] route_c;
    logic none_c;

    logic setup, acc, wr, rd, hit, go_old;
    logic [4:0] chs;

    // Access completes on the cycle after setup: no wait state, registered answer.
    assign setup = psel && !penable;
    assign acc = psel && penable && pready_reg;
    assign wr = acc && pwrite;
    assign rd = setup && !pwrite;
    assign go_old = ctrl_reg[ACR_GO_BIT];
    assign chs = ctrl_reg[ACR_CHS_MSB:ACR_CHS_LSB];

    always_comb begin
        hit = 1'b0;
        unique case (paddr)
            ACR_OFF_CTRL0, ACR_OFF_STAT, ACR_OFF_MASK, ACR_OFF_RESULT, ACR_OFF_TRIG: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end

    always_comb begin
        ctrl_next = ctrl_reg;
        stat_next = stat_reg;
        mask_next = mask_reg;
        res_next = res_reg;
        state_next = state_reg;
        start_next = 1'b0;
        abort_next = 1'b0;
        if (wr && paddr == ACR_OFF_CTRL0) begin
            ctrl_next = pwdata[7:0] & ACR_CTRL_WMASK;
        end
        if (wr && paddr == ACR_OFF_MASK) begin
            mask_next = pwdata[1:0];
        end
        if (wr && paddr == ACR_OFF_STAT) begin
            stat_next = stat_reg & ~pwdata[1:0];
        end
        unique case (state_reg)
            ACR_IDLE: begin
                // Start by software write or special event trigger, only when enabled.
                if (ctrl_next[ACR_GO_BIT] && !go_old) begin
                    start_next = ctrl_next[ACR_EN_BIT];
                    state_next = ctrl_next[ACR_EN_BIT] ? ACR_CONV : ACR_IDLE;
                    ctrl_next[ACR_GO_BIT] = ctrl_next[ACR_EN_BIT];
                end else if (special_trigger && ctrl_next[ACR_EN_BIT]) begin
                    ctrl_next[ACR_GO_BIT] = 1'b1;
                    start_next = 1'b1;
                    state_next = ACR_CONV;
                end else begin
                    ctrl_next[ACR_GO_BIT] = 1'b0;
                end
            end
            ACR_CONV: begin
                if (engine_done) begin
                    res_next = engine_result;
                    stat_next[0] = 1'b1;
                    state_next = ACR_FINISH;
                end else if (!ctrl_next[ACR_GO_BIT] || !ctrl_next[ACR_EN_BIT]) begin
                    // Engine fills unconverted bits with the last converted bit on abort.
                    abort_next = 1'b1;
                    res_next = engine_result;
                    stat_next[1] = 1'b1;
                    ctrl_next[ACR_GO_BIT] = 1'b0;
                    state_next = ACR_IDLE;
                end
            end
            ACR_FINISH: begin
                ctrl_next[ACR_GO_BIT] = 1'b0;
                state_next = ACR_IDLE;
            end
            default: state_next = ACR_IDLE;
        endcase
        // Clear by software loses to a fresh hardware set.
        if (state_reg == ACR_CONV && engine_done) begin
            stat_next[0] = 1'b1;
        end
        if (state_reg == ACR_CONV && engine_done) begin
            ctrl_next[ACR_GO_BIT] = 1'b1;
        end
    end

    acr_mux u_mux (
        .input_channel_selector(chs),
        .converter_enable(ctrl_reg[ACR_EN_BIT]),
        .route_onehot(route_c),
        .route_none(none_c)
    );

    always_comb begin
        prdata_next = prdata_reg;
        pready_next = setup;
        pslverr_next = setup && !hit;
        if (rd) begin
            unique case (paddr)
                ACR_OFF_CTRL0: prdata_next = {24'h000000, ctrl_reg};
                ACR_OFF_STAT: prdata_next = {30'h00000000, stat_reg};
                ACR_OFF_MASK: prdata_next = {30'h00000000, mask_reg};
                ACR_OFF_RESULT: prdata_next = {22'h000000, res_reg};
                default: prdata_next = 32'h00000000;
            endcase
        end
        irq_next = |(stat_next & mask_next);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= ACR_CTRL_RESET;
            stat_reg <= 2'h0;
            mask_reg <= 2'h0;
            res_reg <= 10'h000;
            state_reg <= ACR_IDLE;
            start_reg <= 1'b0;
            abort_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            irq_reg <= 1'b0;
            route_reg <= 13'h0000;
            none_reg <= 1'b1;
        end else begin
            ctrl_reg <= ctrl_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            res_reg <= res_next;
            state_reg <= state_next;
            start_reg <= start_next;
            abort_reg <= abort_next;
            prdata_reg <= prdata_next;
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            irq_reg <= irq_next;
            route_reg <= route_c;
            none_reg <= none_c;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign engine_start = start_reg;
    assign engine_abort = abort_reg;
    assign converter_enable = ctrl_reg[ACR_EN_BIT];
    assign route_onehot = route_reg;
    assign route_none = none_reg;
    assign result_high = {6'h00, res_reg[9:8]};
    assign result_low = res_reg[7:0];
    assign irq = irq_reg;

    // Register fields: the top bit never holds a one, neither stored nor read back.
    a_bit7_zero: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[7] == 1'b0)
        else $error("control bit 7 set");

    a_bit7_read: assert property (@(posedge pclk) disable iff (!presetn)
        rd && paddr == ACR_OFF_CTRL0 |=> prdata_reg[7] == 1'b0)
        else $error("control bit 7 read as one");

    // Routing follows the registered selector one clock later.
    a_chs_analog: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[ACR_EN_BIT] && chs <= ACR_CHS_AN9
        |=> route_onehot == (13'h0001 << $past(chs)))
        else $error("analogue input not routed");

    a_one_route: assert property (@(posedge pclk) disable iff (!presetn)
        $onehot0(route_onehot))
        else $error("more than one input routed");

    a_reserved_none: assert property (@(posedge pclk) disable iff (!presetn)
        chs >= ACR_CHS_RSV_LO && chs <= ACR_CHS_RSV_HI |=> route_none)
        else $error("reserved code routed");

    a_temp_route: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[ACR_EN_BIT] && chs == ACR_CHS_TEMP |=> route_onehot[ACR_SRC_TEMP])
        else $error("temperature indicator not routed");

    a_dac_route: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[ACR_EN_BIT] && chs == ACR_CHS_DAC |=> route_onehot[ACR_SRC_DAC])
        else $error("converter output not routed");

    a_fvr_route: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_reg[ACR_EN_BIT] && chs == ACR_CHS_FVR |=> route_onehot[ACR_SRC_FVR])
        else $error("voltage reference not routed");

    // The busy bit mirrors the conversion state machine.
    a_go_on_start: assert property (@(posedge pclk) disable iff (!presetn)
        start_reg |-> ctrl_reg[ACR_GO_BIT] && state_reg == ACR_CONV)
        else $error("start without busy");

    a_write_starts: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_IDLE && wr && paddr == ACR_OFF_CTRL0 && pwdata[ACR_GO_BIT]
        && pwdata[ACR_EN_BIT] |=> start_reg && state_reg == ACR_CONV)
        else $error("busy write did not start");

    a_busy_in_conv: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_CONV |-> ctrl_reg[ACR_GO_BIT])
        else $error("busy low during conversion");

    a_done_clears: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_CONV && engine_done |=> ##1 !ctrl_reg[ACR_GO_BIT])
        else $error("busy not cleared after done");

    a_idle_not_busy: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_FINISH |=> !ctrl_reg[ACR_GO_BIT])
        else $error("busy while idle");

    a_idle_clear: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_IDLE |-> !ctrl_reg[ACR_GO_BIT])
        else $error("busy set with no conversion");

    a_disable_none: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg[ACR_EN_BIT] |=> route_onehot == 13'h0000)
        else $error("route while disabled");

    a_start_enabled: assert property (@(posedge pclk) disable iff (!presetn)
        start_reg |-> ctrl_reg[ACR_EN_BIT])
        else $error("start while disabled");

    a_disabled_nostart: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl_reg[ACR_EN_BIT] && !wr |=> !start_reg)
        else $error("disabled converter started");

    a_field_write: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == ACR_OFF_CTRL0 |=> ctrl_reg[ACR_EN_BIT] == $past(pwdata[ACR_EN_BIT])
        && chs == $past(pwdata[ACR_CHS_MSB:ACR_CHS_LSB]))
        else $error("control field write lost");

    // Completion and abort side effects.
    a_done_flag: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_CONV && engine_done |=> stat_reg[0] && res_reg == $past(engine_result))
        else $error("done flag or result missing");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        irq_reg == |(stat_reg & mask_reg))
        else $error("interrupt level wrong");

    a_done_no_abort: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_CONV && engine_done |=> !abort_reg && state_reg == ACR_FINISH)
        else $error("completion treated as abort");

    a_abort_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        abort_reg |-> state_reg == ACR_IDLE && !ctrl_reg[ACR_GO_BIT])
        else $error("abort left busy");

    a_clear_aborts: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_CONV && !engine_done && wr && paddr == ACR_OFF_CTRL0
        && !pwdata[ACR_GO_BIT] |=> abort_reg && stat_reg[1] && state_reg == ACR_IDLE)
        else $error("busy clear did not abort");

    a_trig_start: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ACR_IDLE && special_trigger && ctrl_reg[ACR_EN_BIT] && !wr
        |=> start_reg && ctrl_reg[ACR_GO_BIT])
        else $error("trigger ignored");
endmodule

// ---- src/acr_mux.sv ----
// Analogue input route decoder: one-hot connect enables from the channel selector.
`timescale 1ns/1ns
module acr_mux (
    input wire logic [4:0] input_channel_selector,
    input wire logic converter_enable,
    output logic [acr_pkg::ACR_NSRC-1:0] route_onehot,
    output logic route_none
);
    import acr_pkg::*;

    genvar g;
    generate
        for (g = 0; g < ACR_NSRC; g++) begin : g_src
            logic [4:0] code;
            if (g <= 9) begin : g_an
                assign code = 5'(g);
            end else if (g == 10) begin : g_t
                assign code = ACR_CHS_TEMP;
            end else if (g == 11) begin : g_d
                assign code = ACR_CHS_DAC;
            end else begin : g_f
                assign code = ACR_CHS_FVR;
            end
            // Disabled converter connects nothing so the front end draws no current.
            assign route_onehot[g] = converter_enable && (input_channel_selector == code);
        end
    endgenerate

    assign route_none = ~|route_onehot;
endmodule

// ---- src/acr_pkg.sv ----
// Package with register map, field layout and state encodings of the converter control block.
package acr_pkg;
    localparam logic [11:0] ACR_OFF_CTRL0 = 12'h000;
    localparam logic [11:0] ACR_OFF_STAT = 12'h004;
    localparam logic [11:0] ACR_OFF_MASK = 12'h008;
    localparam logic [11:0] ACR_OFF_RESULT = 12'h00C;
    localparam logic [11:0] ACR_OFF_TRIG = 12'h010;
    localparam int ACR_EN_BIT = 0;
    localparam int ACR_GO_BIT = 1;
    localparam int ACR_CHS_LSB = 2;
    localparam int ACR_CHS_MSB = 6;
    localparam logic [7:0] ACR_CTRL_WMASK = 8'h7F;
    localparam logic [7:0] ACR_CTRL_RESET = 8'h00;
    localparam logic [4:0] ACR_CHS_AN9 = 5'h09;
    localparam logic [4:0] ACR_CHS_RSV_LO = 5'h0C;
    localparam logic [4:0] ACR_CHS_RSV_HI = 5'h1C;
    localparam logic [4:0] ACR_CHS_TEMP = 5'h1D;
    localparam logic [4:0] ACR_CHS_DAC = 5'h1E;
    localparam logic [4:0] ACR_CHS_FVR = 5'h1F;
    localparam int ACR_NSRC = 13;
    localparam logic [3:0] ACR_SRC_TEMP = 4'hA;
    localparam logic [3:0] ACR_SRC_DAC = 4'hB;
    localparam logic [3:0] ACR_SRC_FVR = 4'hC;
    localparam logic [1:0] ACR_IRQ_DONE = 2'h1;
    localparam logic [1:0] ACR_IRQ_ABORT = 2'h2;
    localparam int ACR_RES_W = 10;
    typedef enum logic [1:0] {
        ACR_IDLE = 2'b00,
        ACR_CONV = 2'b01,
        ACR_FINISH = 2'b11
    } acr_state_e;
endpackage

// ---- test/test_acr_ctrl.sv ----
// Self-checking testbench for the converter control register block over APB.
`timescale 1ns/1ns
module test_acr_ctrl;
    import acr_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic special_trigger = 1'b0;
    logic engine_done = 1'b0;
    logic [ACR_RES_W-1:0] engine_result = 10'h000;
    logic [31:0] prdata;
    logic pready, pslverr, engine_start, engine_abort, converter_enable, route_none, irq;
    logic [ACR_NSRC-1:0] route_onehot;
    logic [7:0] result_high, result_low;
    logic [31:0] rd;
    logic err;
    int n_errors = 0;
    int tests_run = 0;
    int n_start = 0;
    int n_abort = 0;
    int s0;

    acr_ctrl i_acr_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .special_trigger(special_trigger), .engine_done(engine_done),
        .engine_result(engine_result), .engine_start(engine_start),
        .engine_abort(engine_abort), .converter_enable(converter_enable),
        .route_onehot(route_onehot), .route_none(route_none), .result_high(result_high),
        .result_low(result_low), .irq(irq));

    always #10 pclk = ~pclk;

    // Pulse counters for the engine handshake outputs.
    always @(posedge pclk) begin
        if (engine_start === 1'b1) n_start++;
        if (engine_abort === 1'b1) n_abort++;
    end

    task automatic print_verdict();
        $display("Checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(name, rd, exp);
    endtask

    task automatic pulse_done(input logic [ACR_RES_W-1:0] r);
        @(posedge pclk);
        engine_done <= 1'b1;
        engine_result <= r;
        @(posedge pclk);
        engine_done <= 1'b0;
    endtask

    function automatic logic [12:0] exp_route(input int c);
        if (c < 10) return 13'h0001 << c;
        if (c == 29) return 13'h0400;
        if (c == 30) return 13'h0800;
        if (c == 31) return 13'h1000;
        return 13'h0000;
    endfunction

    initial begin
        #200000;
        n_errors++;
        print_verdict();
    end

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl_reset", ACR_OFF_CTRL0, 32'h0);
        check("none_reset", route_none, 1);
        apb(1'b1, ACR_OFF_CTRL0, 32'hFD);
        rd_chk("ctrl_bit7", ACR_OFF_CTRL0, 32'h7D);
        for (int c = 0; c < 32; c++) begin
            apb(1'b1, ACR_OFF_CTRL0, {25'h0, c[4:0], 2'b01});
            repeat (2) @(posedge pclk);
            if (c != 10 && c != 11) begin
                check("route", route_onehot, exp_route(c));
                check("none", route_none, (c >= 12 && c <= 28));
            end
        end
        apb(1'b1, ACR_OFF_CTRL0, 32'h02);
        repeat (2) @(posedge pclk);
        check("route_off", route_onehot, 0);
        check("enable_off", converter_enable, 0);
        rd_chk("ctrl_nogo", ACR_OFF_CTRL0, 32'h0);
        apb(1'b1, ACR_OFF_CTRL0, 32'h01);
        s0 = n_start;
        apb(1'b1, ACR_OFF_CTRL0, 32'h03);
        apb(1'b1, ACR_OFF_MASK, 32'h1);
        rd_chk("ctrl_busy", ACR_OFF_CTRL0, 32'h03);
        check("start_pulse", n_start - s0, 1);
        pulse_done(10'h2A5);
        repeat (3) @(posedge pclk);
        rd_chk("ctrl_done", ACR_OFF_CTRL0, 32'h01);
        check("res_high", result_high, 8'h02);
        check("res_low", result_low, 8'hA5);
        rd_chk("result", ACR_OFF_RESULT, 32'h2A5);
        rd_chk("stat_done", ACR_OFF_STAT, 32'h1);
        check("irq_on", irq, 1);
        apb(1'b1, ACR_OFF_STAT, 32'h1);
        repeat (2) @(posedge pclk);
        check("irq_off", irq, 0);
        apb(1'b1, ACR_OFF_CTRL0, 32'h03);
        engine_result <= 10'h155;
        apb(1'b1, ACR_OFF_CTRL0, 32'h01);
        repeat (3) @(posedge pclk);
        check("abort_pulse", n_abort, 1);
        rd_chk("ctrl_abort", ACR_OFF_CTRL0, 32'h01);
        rd_chk("partial", ACR_OFF_RESULT, 32'h155);
        rd_chk("stat_abort", ACR_OFF_STAT, 32'h2);
        s0 = n_start;
        @(posedge pclk);
        special_trigger <= 1'b1;
        @(posedge pclk);
        special_trigger <= 1'b0;
        repeat (2) @(posedge pclk);
        rd_chk("ctrl_trig", ACR_OFF_CTRL0, 32'h03);
        check("trig_start", n_start - s0, 1);
        pulse_done(10'h3FF);
        repeat (3) @(posedge pclk);
        rd_chk("ctrl_trig_done", ACR_OFF_CTRL0, 32'h01);
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped_err", err, 1);
        check("unmapped_data", rd, 0);
        apb(1'b1, ACR_OFF_RESULT, 32'h0);
        rd_chk("result_ro", ACR_OFF_RESULT, 32'h3FF);
        apb(1'b1, ACR_OFF_CTRL0, 32'h7D);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("ctrl_rereset", ACR_OFF_CTRL0, 32'h0);
        check("none_rereset", route_none, 1);
        print_verdict();
    end
endmodule
